// >>> logic/gss_status_select.sv
`timescale 1ns/1ps
// What this block does
// - code 0x158 shows fifo not-empty, pins 1-8
// - codes 0x230-0x233 pulse on alarm channel trigger
// - alarm pulse width comes from a setting
// - codes 0x250/0x251 pulse when timer reaches end
// - code 0x373 shows dsp idle, pins 1-8
// - alarm and timer codes work on all sixteen pins
module gss_status_select
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // per-pin function selection and alarm pulse setting
  input wire gss_pkg::gss_sel_t pin_sel,
  input wire logic [gss_pkg::PW_W-1:0] alarm_pulse_width,
  // status sources
  input wire gss_pkg::gss_src_t src,
  // pin side
  output logic [gss_pkg::GPIO_COUNT-1:0] gpio_out,
  output logic [gss_pkg::GPIO_COUNT-1:0] gpio_oe
);

  // ----------------------------------------------------------------
  // routing function
  // ----------------------------------------------------------------

  // returns {drive, level} for one pin; unknown codes leave the pin undriven
  function automatic logic [1:0] gss_route
  (
    input logic [gss_pkg::CODE_W-1:0] code,
    input int unsigned pin,
    input logic fifo_lvl,
    input logic [gss_pkg::ALARM_CH-1:0] alarm_lvl,
    input logic [gss_pkg::TIMER_CH-1:0] timer_lvl,
    input logic idle_lvl
  );
    logic low_pin;
    logic [1:0] res;
    int unsigned idx;
    low_pin = (pin < gss_pkg::LOW_PIN_COUNT);
    res = 2'h0;
    idx = 0;
    // fifo level only on the low pins
    if (code == gss_pkg::FN_FIFO_NOT_EMPTY && low_pin)
    begin
      res = {1'b1, fifo_lvl};
    end
    // alarm channels, any pin
    else if (code >= gss_pkg::FN_ALARM_FIRST && code <= gss_pkg::FN_ALARM_LAST)
    begin
      idx = 32'(code - gss_pkg::FN_ALARM_FIRST);
      res = {1'b1, alarm_lvl[idx]};
    end
    // timers, any pin
    else if (code >= gss_pkg::FN_TIMER_FIRST && code <= gss_pkg::FN_TIMER_LAST)
    begin
      idx = 32'(code - gss_pkg::FN_TIMER_FIRST);
      res = {1'b1, timer_lvl[idx]};
    end
    // dsp idle level only on the low pins
    else if (code == gss_pkg::FN_DSP_IDLE && low_pin)
    begin
      res = {1'b1, idle_lvl};
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  gss_pkg::gss_state_t st_r; // registered state
  gss_pkg::gss_state_t st_nxt; // next state
  logic [gss_pkg::ALARM_CH-1:0] alarm_pulse; // alarm pulse levels, next cycle
  logic [gss_pkg::TIMER_CH-1:0] timer_pulse; // timer one-cycle pulses
  logic [gss_pkg::PW_W-1:0] pw_load; // pulse length to load on a trigger
  // width that the exact-length check watches, one of those the bench drives
  localparam logic [gss_pkg::PW_W-1:0] PW_CHECK = 8'h03;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------

  // pulse shaping for events, plain pass-through for levels
  always_comb
  begin
    logic [1:0] r;
    r = 2'h0;
    st_nxt = st_r;
    alarm_pulse = '0;
    timer_pulse = '0;
    // a zero setting still gives a visible one-cycle pulse
    pw_load = (alarm_pulse_width == gss_pkg::PW_ZERO) ? gss_pkg::PW_MIN : alarm_pulse_width;
    st_nxt.alarm_prev = src.alarm_cond;
    st_nxt.timer_prev = src.timer_done;
    // alarm channels: a new trigger reloads, even mid-pulse
    for (int i = 0; i < gss_pkg::ALARM_CH; i++)
    begin
      if (src.alarm_cond[i] && !st_r.alarm_prev[i])
      begin
        st_nxt.alarm_cnt[i] = pw_load;
      end
      else if (st_r.alarm_cnt[i] != gss_pkg::PW_ZERO)
      begin
        st_nxt.alarm_cnt[i] = st_r.alarm_cnt[i] - gss_pkg::PW_STEP;
      end
      alarm_pulse[i] = (st_nxt.alarm_cnt[i] != gss_pkg::PW_ZERO);
    end
    // timers: one cycle on reaching the final count
    for (int t = 0; t < gss_pkg::TIMER_CH; t++)
    begin
      timer_pulse[t] = src.timer_done[t] && !st_r.timer_prev[t];
    end
    // per-pin routing; levels pass straight through, no latching
    for (int p = 0; p < gss_pkg::GPIO_COUNT; p++)
    begin
      r = gss_route(pin_sel[p], p, src.fifo_not_empty, alarm_pulse, timer_pulse,
        !src.dsp_busy);
      st_nxt.pin_oe[p] = r[1];
      st_nxt.pin_val[p] = r[1] & r[0];
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // synchronous reset clears everything, pins undriven and low
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign gpio_out = st_r.pin_val;
  assign gpio_oe = st_r.pin_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // alarm channel one rises on pin 4 with the channel selected
  sequence s_alarm_rise;
    pin_sel[3] == gss_pkg::FN_ALARM_FIRST && $rose(src.alarm_cond[0]);
  endsequence

  // timer two reaches its end on pin 16
  sequence s_timer_end;
    pin_sel[15] == gss_pkg::FN_TIMER_LAST && $rose(src.timer_done[1]);
  endsequence

  // fifo level on pin 1, one cycle behind its source
  property p_fifo_level;
    pin_sel[0] == gss_pkg::FN_FIFO_NOT_EMPTY |=>
      gpio_oe[0] && gpio_out[0] == $past(src.fifo_not_empty);
  endproperty
  a_fifo_level: assert property (p_fifo_level) else $error("fifo level not on pin 1");

  property p_alarm_pulse;
    s_alarm_rise |=> gpio_oe[3] && gpio_out[3];
  endproperty
  a_alarm_pulse: assert property (p_alarm_pulse) else $error("alarm pulse missing");

  property p_alarm_width;
    $rose(src.alarm_cond[0]) |=>
      st_r.alarm_cnt[0] == (($past(alarm_pulse_width) == gss_pkg::PW_ZERO) ?
        gss_pkg::PW_MIN : $past(alarm_pulse_width));
  endproperty
  a_alarm_width: assert property (p_alarm_width) else $error("alarm width not loaded");

  // setting three with no retrigger: pin high three cycles, then low
  sequence s_alarm_w3_hold;
    s_alarm_rise ##0 alarm_pulse_width == PW_CHECK ##1
      (pin_sel[3] == gss_pkg::FN_ALARM_FIRST && !$rose(src.alarm_cond[0])) [*3];
  endsequence

  property p_alarm_three;
    s_alarm_w3_hold |-> gpio_out[3] ##1 !gpio_out[3];
  endproperty
  a_alarm_three: assert property (p_alarm_three) else $error("alarm pulse length wrong");

  property p_timer_pulse;
    s_timer_end ##1 pin_sel[15] == gss_pkg::FN_TIMER_LAST |-> gpio_out[15] ##1 !gpio_out[15];
  endproperty
  a_timer_pulse: assert property (p_timer_pulse) else $error("timer pulse not one cycle");

  // dsp idle level on pin 8, inverted busy flag
  property p_dsp_idle;
    pin_sel[7] == gss_pkg::FN_DSP_IDLE |=> gpio_oe[7] && gpio_out[7] == !$past(src.dsp_busy);
  endproperty
  a_dsp_idle: assert property (p_dsp_idle) else $error("dsp idle level wrong");

  property p_high_pins;
    (pin_sel[15] >= gss_pkg::FN_ALARM_FIRST && pin_sel[15] <= gss_pkg::FN_TIMER_LAST &&
      (pin_sel[15] <= gss_pkg::FN_ALARM_LAST || pin_sel[15] >= gss_pkg::FN_TIMER_FIRST))
      |=> gpio_oe[15];
  endproperty
  a_high_pins: assert property (p_high_pins) else $error("event code refused on pin 16");

  // restricted levels must leave pin 9 undriven
  property p_low_only;
    (pin_sel[8] == gss_pkg::FN_DSP_IDLE || pin_sel[8] == gss_pkg::FN_FIFO_NOT_EMPTY)
      |=> !gpio_oe[8] && !gpio_out[8];
  endproperty
  a_low_only: assert property (p_low_only) else $error("restricted code drove pin 9");

  property p_follow;
    pin_sel[0] == gss_pkg::FN_FIFO_NOT_EMPTY && $stable(pin_sel[0]) &&
      $changed(src.fifo_not_empty) |=> $changed(gpio_out[0]);
  endproperty
  a_follow: assert property (p_follow) else $error("level did not follow source");

  // dsp idle level follows the busy flag too, no hold or shaping
  property p_follow_idle;
    pin_sel[7] == gss_pkg::FN_DSP_IDLE && $stable(pin_sel[7]) &&
      $changed(src.dsp_busy) |=> $changed(gpio_out[7]);
  endproperty
  a_follow_idle: assert property (p_follow_idle) else $error("idle level did not follow");

endmodule

// >>> include/gss_pkg.sv
package gss_pkg;

  // ----------------------------------------------------------------
  // pin and code geometry
  // ----------------------------------------------------------------
  localparam int unsigned GPIO_COUNT = 16; // all selectable pins
  localparam int unsigned LOW_PIN_COUNT = 8; // pins that carry the restricted levels
  localparam int unsigned CODE_W = 10; // width of one function code
  localparam int unsigned ALARM_CH = 4; // alarm channels one to four
  localparam int unsigned TIMER_CH = 2; // timers one and two
  localparam int unsigned PW_W = 8; // width of the alarm pulse-width setting

  // ----------------------------------------------------------------
  // function codes
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] FN_FIFO_NOT_EMPTY = 10'h158; // log fifo holds entries
  localparam logic [CODE_W-1:0] FN_ALARM_FIRST = 10'h230; // alarm channel one
  localparam logic [CODE_W-1:0] FN_ALARM_LAST = 10'h233; // alarm channel four
  localparam logic [CODE_W-1:0] FN_TIMER_FIRST = 10'h250; // timer one
  localparam logic [CODE_W-1:0] FN_TIMER_LAST = 10'h251; // timer two
  localparam logic [CODE_W-1:0] FN_DSP_IDLE = 10'h373; // dsp power state

  // ----------------------------------------------------------------
  // small constants
  // ----------------------------------------------------------------
  localparam logic [PW_W-1:0] PW_ZERO = 8'h00; // setting that means shortest pulse
  localparam logic [PW_W-1:0] PW_MIN = 8'h01; // shortest pulse, one cycle
  localparam logic [PW_W-1:0] PW_STEP = 8'h01; // countdown step

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef logic [GPIO_COUNT-1:0][CODE_W-1:0] gss_sel_t; // one code per pin

  // status signals from the logger, alarm, timer and dsp blocks
  typedef struct packed {
    logic fifo_not_empty; // level, high while the log fifo has entries
    logic [ALARM_CH-1:0] alarm_cond; // level, trigger condition met
    logic [TIMER_CH-1:0] timer_done; // level, timer at final count
    logic dsp_busy; // level, high while the dsp is busy
  } gss_src_t;

  // whole state of the selector
  typedef struct packed {
    logic [ALARM_CH-1:0] alarm_prev; // last seen trigger condition
    logic [ALARM_CH-1:0][PW_W-1:0] alarm_cnt; // remaining pulse cycles
    logic [TIMER_CH-1:0] timer_prev; // last seen final-count level
    logic [GPIO_COUNT-1:0] pin_val; // registered pin levels
    logic [GPIO_COUNT-1:0] pin_oe; // registered pin drive enables
  } gss_state_t;

endpackage

// >>> tb/gss_host_mon.sv
`timescale 1ns/1ps
// ----------------------------------------
// host-side pin watcher
// ----------------------------------------
module gss_host_mon
(
  // clock
  input wire logic mclk,
  // pins as the selector leaves them
  input wire logic [gss_pkg::GPIO_COUNT-1:0] gpio_out,
  input wire logic [gss_pkg::GPIO_COUNT-1:0] gpio_oe,
  // levels an outside observer sees
  output logic [gss_pkg::GPIO_COUNT-1:0] pin_lvl
);
  logic [gss_pkg::GPIO_COUNT-1:0] last_r = '0; // previous seen level, known from time zero
  // a floating pin keeps no stale copy: it flips every cycle
  always @(posedge mclk)
  begin
    last_r <= pin_lvl;
  end
  assign pin_lvl = (gpio_oe & gpio_out) | (~gpio_oe & ~last_r);
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // signals and bookkeeping
  // ----------------------------------------
  typedef struct {int cyc; int pin; logic out; logic oe;} gss_note_t;
  logic mclk = 1'b0; // 40 MHz
  logic rst_n = 1'b0; // held low at start
  gss_pkg::gss_sel_t pin_sel = '0;
  logic [gss_pkg::PW_W-1:0] alarm_pulse_width = 8'h00;
  gss_pkg::gss_src_t src = '0;
  logic [15:0] gpio_out, gpio_oe, pin_lvl;
  gss_note_t notes[$]; // expected pin states, oldest first
  int cyc = 0; // rising edges seen
  int error_cnt = 0;
  int n_checks = 0;
  logic [15:0] rnd = 16'hb79f; // lfsr state
  always #12.5 mclk = ~mclk;
  gss_status_select dut_u (.mclk(mclk), .rst_n(rst_n), .pin_sel(pin_sel),
    .alarm_pulse_width(alarm_pulse_width), .src(src), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  gss_host_mon host_u (.mclk(mclk), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_lvl(pin_lvl));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expectation checked just after the dly-th rising edge, the coming one counting as the first
  task automatic note(input int dly, input int p, input logic o, input logic e);
    notes.push_back('{cyc + dly, p, o, e});
  endtask
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // watcher: compare each due note, cap the run
  // ----------------------------------------
  always @(posedge mclk)
  begin
    #1;
    cyc++;
    if (cyc > 1000)
    begin
      error_cnt++;
      final_report();
    end
    while (notes.size() > 0 && notes[0].cyc <= cyc)
    begin
      // undriven pins are judged on the raw output, not the floating wire
      chk({notes[0].oe ? pin_lvl[notes[0].pin] : gpio_out[notes[0].pin],
           gpio_oe[notes[0].pin]}, {notes[0].out, notes[0].oe});
      void'(notes.pop_front());
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // random codes and levels on all pins, including refused placements
  task automatic t_level();
    int k;
    logic [9:0] near_miss[4] = '{gss_pkg::FN_ALARM_FIRST - 10'h001, gss_pkg::FN_ALARM_LAST + 10'h001,
      gss_pkg::FN_TIMER_FIRST - 10'h001, gss_pkg::FN_TIMER_LAST + 10'h001}; // just outside ranges
    for (int n = 0; n < 40; n++)
    begin
      @(negedge mclk);
      rnd = lfsr(rnd);
      src.fifo_not_empty = rnd[0];
      src.dsp_busy = rnd[1];
      for (int p = 0; p < 16; p++)
      begin
        rnd = lfsr(rnd);
        k = rnd[1:0];
        case (k)
          0: pin_sel[p] = gss_pkg::FN_FIFO_NOT_EMPTY;
          1: pin_sel[p] = gss_pkg::FN_DSP_IDLE;
          2: pin_sel[p] = rnd[4] ? gss_pkg::FN_TIMER_FIRST + 10'(rnd[2])
                                 : gss_pkg::FN_ALARM_FIRST + 10'(rnd[3:2]);
          default: pin_sel[p] = rnd[5] ? {2'b00, rnd[9:2]} : near_miss[rnd[3:2]]; // refused codes
        endcase
        if (k == 0) note(1, p, p < 8 && src.fifo_not_empty, p < 8);
        else if (k == 1) note(1, p, p < 8 && !src.dsp_busy, p < 8);
        else note(1, p, 1'b0, k == 2);
      end
    end
    $display("level test done");
  endtask
  // alarm pulses on each channel with several widths, random pin except channel one on pin 4
  task automatic t_alarm();
    int p, wn;
    logic [7:0] wtab[3] = '{8'h00, 8'h01, 8'h03};
    for (int ch = 0; ch < 4; ch++)
      for (int wi = 0; wi < 3; wi++)
      begin
        @(negedge mclk);
        rnd = lfsr(rnd);
        p = (ch == 0) ? 3 : int'(rnd[3:0]); // channel one on pin 4, where the checks look
        pin_sel[p] = gss_pkg::FN_ALARM_FIRST + 10'(ch);
        alarm_pulse_width = wtab[wi];
        src.alarm_cond[ch] = 1'b1;
        wn = (wtab[wi] == 8'h00) ? 1 : int'(wtab[wi]);
        for (int i = 1; i <= wn + 1; i++) note(i, p, i <= wn, 1'b1);
        repeat (wn + 2) @(negedge mclk);
        src.alarm_cond[ch] = 1'b0;
        @(negedge mclk);
      end
    $display("alarm test done");
  endtask
  // timer end pulses last one cycle though the source stays high
  task automatic t_timer();
    int p;
    for (int t = 0; t < 2; t++)
    begin
      @(negedge mclk);
      rnd = lfsr(rnd);
      p = (t == 1) ? 15 : int'(rnd[3:0]); // timer two on pin 16, where the checks look
      pin_sel[p] = gss_pkg::FN_TIMER_FIRST + 10'(t);
      src.timer_done[t] = 1'b1;
      for (int i = 1; i <= 3; i++) note(i, p, i == 1, 1'b1);
      repeat (4) @(negedge mclk);
      src.timer_done[t] = 1'b0;
    end
    $display("timer test done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    t_level();
    t_alarm();
    t_timer();
    repeat (5) @(negedge mclk);
    final_report();
  end
endmodule
